/* File: shared/pan_defines.svh */
// constants of the auto-negotiation control block
`ifndef PAN_DEFINES_SVH
`define PAN_DEFINES_SVH

`define PAN_REG_CONTROL 5'h00
`define PAN_REG_STATUS 5'h01
`define PAN_REG_ADVERT 5'h04
`define PAN_REG_PARTNER 5'h05
`define PAN_REG_EXPANSION 5'h06
`define PAN_REG_SUMMARY 5'h10

`define PAN_CTL_RESET 15
`define PAN_CTL_SPEED 13
`define PAN_CTL_ENABLE 12
`define PAN_CTL_ISOLATE 10
`define PAN_CTL_RESTART 9
`define PAN_CTL_DUPLEX 8
`define PAN_CTL_INIT 16'h3000
`define PAN_CTL_WR_MASK 16'h3500

`define PAN_STATUS_CONST 16'h7848
`define PAN_ST_COMPLETE 5
`define PAN_ST_RFAULT 4
`define PAN_ST_LINK 2

`define PAN_ADV_SELECTOR 16'h0001
`define PAN_ADV_ALL 16'h01E1
`define PAN_ADV_HALF 16'h00A1
`define PAN_ADV_T100FD 8
`define PAN_ADV_T100HD 7
`define PAN_ADV_T10FD 6
`define PAN_ADV_T10HD 5
`define PAN_PAGE_ACK 14
`define PAN_PAGE_NP 15
`define PAN_PAGE_RF 13
`define PAN_PD_100 16'h0081
`define PAN_PD_10 16'h0021

`define PAN_ISO_SW_US 100
`define PAN_ISO_RST_US 500
`define PAN_BREAK_MS 1500
`define PAN_CLK_MHZ 20
`define PAN_ISO_STEP 16'h0001

`endif

/* File: shared/pan_pkg.sv */
// types of the auto-negotiation control block
package pan_pkg;
    typedef enum logic [2:0] {
        PAN_FORCED,
        PAN_BREAK,
        PAN_NEGOTIATE,
        PAN_ACK,
        PAN_LINK_UP
    } pan_state_e;
    typedef logic [15:0] pan_word_t;
endpackage

/* File: hdl/pan_timer.sv */
// down-counting timer with load and expiry flag
`timescale 1ns/1ps
module pan_timer #(
    parameter int WIDTH = 32
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_value,
    output logic expired
);
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;

    always_comb begin
        next_count = count;
        if (load) begin
            next_count = load_value;
        end else if (count != '0) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign expired = (count == '0) && !load;
endmodule // pan_timer

/* File: hdl/pan_autoneg.sv */
// auto-negotiation control with management registers
`timescale 1ns/1ps
`include "pan_defines.svh"
module pan_autoneg #(
    parameter int BREAK_CYCLES = `PAN_BREAK_MS * `PAN_CLK_MHZ * 1000,
    parameter int ISO_RST_CYCLES = `PAN_ISO_RST_US * `PAN_CLK_MHZ - 1,
    parameter int ISO_SW_CYCLES = `PAN_ISO_SW_US * `PAN_CLK_MHZ - 1,
    parameter int NEG_CYCLES = 2000 * `PAN_CLK_MHZ * 1000
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic advert_strap_pin,
    input wire logic [4:0] reg_addr,
    input wire logic reg_write,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    input wire logic link_pulse_rx,
    input wire logic [15:0] page_rx_word,
    input wire logic page_rx_valid,
    input wire logic link10_good,
    input wire logic link100_good,
    output logic flp_enable,
    output logic [15:0] flp_word,
    output logic tx_silence,
    output logic isolated,
    output logic link_up,
    output logic speed_100,
    output logic full_duplex
);
    // strap, link and pulse inputs pass two flip-flops before use; page_rx_valid and page_rx_word are used directly
    logic [1:0] strap_sync;
    logic [1:0] l10_sync;
    logic [1:0] l100_sync;
    logic [1:0] pulse_sync;
    logic strap_q;
    logic l10;
    logic l100;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            l10_sync <= 2'h0;
            l100_sync <= 2'h0;
            pulse_sync <= 2'h0;
        end else begin
            l10_sync <= {l10_sync[0], link10_good};
            l100_sync <= {l100_sync[0], link100_good};
            pulse_sync <= {pulse_sync[0], link_pulse_rx};
        end
    end
    // strap chain runs through reset so the pin has settled at release
    always_ff @(posedge clk) begin
        strap_sync <= {strap_sync[0], advert_strap_pin};
    end
    assign strap_q = strap_sync[1];
    assign l10 = l10_sync[1];
    assign l100 = l100_sync[1];

    pan_pkg::pan_state_e state;
    pan_pkg::pan_state_e next_state;
    pan_pkg::pan_word_t ctl;
    pan_pkg::pan_word_t next_ctl;
    pan_pkg::pan_word_t adv;
    pan_pkg::pan_word_t next_adv;
    pan_pkg::pan_word_t partner;
    pan_pkg::pan_word_t next_partner;
    logic complete;
    logic next_complete;
    logic pd_fault;
    logic next_pd_fault;
    logic page_rcvd;
    logic next_page_rcvd;
    logic partner_able;
    logic next_partner_able;
    logic strap_pending;
    logic next_strap_pending;
    logic iso;
    logic next_iso;
    logic sw_reset;
    logic enable_armed;
    logic next_enable_armed;
    logic res_100;
    logic next_res_100;
    logic res_fd;
    logic next_res_fd;

    logic brk_load;
    logic brk_done;
    logic neg_load;
    logic neg_done;
    logic iso_load;
    logic [31:0] iso_value;
    logic iso_done;

    logic wr_ctl;
    logic wr_adv;
    logic restart_req;
    logic [15:0] common;
    logic link_any;
    logic one_link;

    assign wr_ctl = reg_write && (reg_addr == `PAN_REG_CONTROL);
    assign wr_adv = reg_write && (reg_addr == `PAN_REG_ADVERT);
    assign sw_reset = wr_ctl && reg_wdata[`PAN_CTL_RESET];
    // restart only counts once a negotiation has finished
    assign restart_req = wr_ctl && reg_wdata[`PAN_CTL_RESTART]
        && ctl[`PAN_CTL_ENABLE] && complete;
    assign common = adv & partner;
    assign link_any = l10 || l100;
    assign one_link = l10 ^ l100;

    pan_timer #(.WIDTH(32)) u_break (
        .clk(clk),
        .nrst(nrst),
        .load(brk_load),
        .load_value(BREAK_CYCLES),
        .expired(brk_done)
    );
    pan_timer #(.WIDTH(32)) u_neg (
        .clk(clk),
        .nrst(nrst),
        .load(neg_load),
        .load_value(NEG_CYCLES),
        .expired(neg_done)
    );
    pan_timer #(.WIDTH(32)) u_iso (
        .clk(clk),
        .nrst(nrst),
        .load(iso_load),
        .load_value(iso_value),
        .expired(iso_done)
    );

    always_comb begin
        next_ctl = ctl;
        next_adv = adv;
        next_strap_pending = 1'b0;
        next_iso = iso;
        next_enable_armed = enable_armed;
        iso_load = 1'b0;
        iso_value = ISO_SW_CYCLES;
        if (strap_pending) begin
            // strap caught after reset release, once synchronised
            next_adv = strap_q ? `PAN_ADV_ALL : `PAN_ADV_HALF;
            iso_load = 1'b1;
            iso_value = ISO_RST_CYCLES;
        end
        if (wr_adv) begin
            next_adv = (reg_wdata & `PAN_ADV_ALL) | `PAN_ADV_SELECTOR;
        end
        if (wr_ctl) begin
            next_ctl = reg_wdata & `PAN_CTL_WR_MASK;
            // a forced start needs enable cleared before it may arm
            if (!reg_wdata[`PAN_CTL_ENABLE]) begin
                next_enable_armed = 1'b1;
            end
            if (!reg_wdata[`PAN_CTL_ENABLE] || enable_armed) begin
                next_ctl[`PAN_CTL_ENABLE] = reg_wdata[`PAN_CTL_ENABLE];
            end else begin
                next_ctl[`PAN_CTL_ENABLE] = ctl[`PAN_CTL_ENABLE];
            end
            if (ctl[`PAN_CTL_ISOLATE] && !reg_wdata[`PAN_CTL_ISOLATE]) begin
                iso_load = 1'b1;
                iso_value = ISO_SW_CYCLES;
            end
            if (reg_wdata[`PAN_CTL_ISOLATE]) begin
                next_iso = 1'b1;
            end
        end
        if (iso && iso_done && !ctl[`PAN_CTL_ISOLATE] && !strap_pending) begin
            next_iso = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst || sw_reset) begin
            ctl <= `PAN_CTL_INIT;
            adv <= `PAN_ADV_ALL;
            strap_pending <= 1'b1;
            iso <= 1'b1;
            enable_armed <= 1'b0;
        end else begin
            ctl <= next_ctl;
            adv <= next_adv;
            strap_pending <= next_strap_pending;
            iso <= next_iso;
            enable_armed <= next_enable_armed;
        end
    end

    always_comb begin
        next_state = state;
        next_partner = partner;
        next_complete = complete;
        next_pd_fault = pd_fault;
        next_page_rcvd = page_rcvd;
        next_partner_able = partner_able;
        next_res_100 = res_100;
        next_res_fd = res_fd;
        brk_load = 1'b0;
        neg_load = 1'b0;
        unique case (state)
            pan_pkg::PAN_FORCED: begin
                next_res_100 = ctl[`PAN_CTL_SPEED];
                next_res_fd = ctl[`PAN_CTL_DUPLEX];
                next_complete = 1'b0;
                if (ctl[`PAN_CTL_ENABLE]) begin
                    next_state = pan_pkg::PAN_BREAK;
                    brk_load = 1'b1;
                end
            end
            pan_pkg::PAN_BREAK: begin
                next_complete = 1'b0;
                // a stale partner flag would block parallel detection
                next_partner_able = 1'b0;
                if (brk_done) begin
                    next_state = pan_pkg::PAN_NEGOTIATE;
                    neg_load = 1'b1;
                end
            end
            pan_pkg::PAN_NEGOTIATE, pan_pkg::PAN_ACK: begin
                if (page_rx_valid) begin
                    next_partner = page_rx_word;
                    next_page_rcvd = 1'b1;
                    next_partner_able = 1'b1;
                    next_state = pan_pkg::PAN_ACK;
                end else if (!partner_able && pulse_sync[1] == 1'b0
                    && link_any) begin
                    if (one_link) begin
                        // partner cannot negotiate: adopt what is heard
                        next_partner = l100 ? `PAN_PD_100 : `PAN_PD_10;
                        next_res_100 = l100;
                        next_res_fd = 1'b0;
                        next_partner_able = 1'b0;
                        next_complete = 1'b1;
                        next_state = pan_pkg::PAN_LINK_UP;
                    end else begin
                        next_pd_fault = 1'b1;
                    end
                end else if (state == pan_pkg::PAN_ACK && link_any) begin
                    // highest common ability wins
                    next_res_100 = common[`PAN_ADV_T100FD]
                        || common[`PAN_ADV_T100HD];
                    next_res_fd = common[`PAN_ADV_T100FD]
                        || (!common[`PAN_ADV_T100HD]
                        && common[`PAN_ADV_T10FD]);
                    next_complete = 1'b1;
                    next_state = pan_pkg::PAN_LINK_UP;
                end else if (neg_done) begin
                    next_state = pan_pkg::PAN_BREAK;
                    brk_load = 1'b1;
                end
            end
            pan_pkg::PAN_LINK_UP: begin
                if (!link_any) begin
                    next_state = pan_pkg::PAN_BREAK;
                    next_complete = 1'b0;
                    brk_load = 1'b1;
                end
            end
        endcase
        if (restart_req) begin
            next_state = pan_pkg::PAN_BREAK;
            next_complete = 1'b0;
            next_partner_able = 1'b0;
            brk_load = 1'b1;
        end
        if (!ctl[`PAN_CTL_ENABLE]) begin
            next_state = pan_pkg::PAN_FORCED;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst || sw_reset) begin
            state <= pan_pkg::PAN_BREAK;
            partner <= 16'h0000;
            complete <= 1'b0;
            pd_fault <= 1'b0;
            page_rcvd <= 1'b0;
            partner_able <= 1'b0;
            res_100 <= 1'b0;
            res_fd <= 1'b0;
        end else begin
            state <= next_state;
            partner <= next_partner;
            complete <= next_complete;
            // pd_fault and page_rcvd stay set until a reset; partner_able clears on each break or restart
            pd_fault <= next_pd_fault;
            page_rcvd <= next_page_rcvd;
            partner_able <= next_partner_able;
            res_100 <= next_res_100;
            res_fd <= next_res_fd;
        end
    end

    always_comb begin
        reg_rdata = 16'h0000;
        unique case (reg_addr)
            `PAN_REG_CONTROL: reg_rdata = ctl | {5'h00, iso, 10'h000};
            `PAN_REG_STATUS: reg_rdata = `PAN_STATUS_CONST
                | {10'h000, complete, partner[`PAN_PAGE_RF], 1'b0,
                   link_up, 2'h1};
            `PAN_REG_ADVERT: reg_rdata = adv;
            `PAN_REG_PARTNER: reg_rdata = partner;
            `PAN_REG_EXPANSION: reg_rdata = {11'h000, pd_fault,
                partner[`PAN_PAGE_NP], 1'b0, page_rcvd,
                partner_able};
            `PAN_REG_SUMMARY: reg_rdata = {13'h0000, full_duplex,
                !speed_100, link_up};
            default: reg_rdata = 16'h0000;
        endcase
    end

    assign flp_enable = (state == pan_pkg::PAN_NEGOTIATE
        || state == pan_pkg::PAN_ACK) && !iso;
    assign flp_word = adv | {1'b0, state == pan_pkg::PAN_ACK,
        14'h0000};
    assign tx_silence = (state == pan_pkg::PAN_BREAK);
    assign isolated = iso;
    assign link_up = (state == pan_pkg::PAN_LINK_UP)
        || (state == pan_pkg::PAN_FORCED && link_any);
    assign speed_100 = res_100;
    assign full_duplex = res_fd;
endmodule // pan_autoneg

/* File: bench/pan_autoneg_checker.sv */
// port assertions for the auto-negotiation control block
`timescale 1ns/1ps
module pan_autoneg_checker #(
    parameter int BREAK_CYCLES = 50,
    parameter int ISO_RST_CYCLES = 20,
    parameter int ISO_SW_CYCLES = 10
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [4:0] reg_addr,
    input wire logic reg_write,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic flp_enable,
    input wire logic [15:0] flp_word,
    input wire logic tx_silence,
    input wire logic isolated,
    input wire logic link_up,
    input wire logic speed_100,
    input wire logic full_duplex
);
    localparam int BREAK_MAX = BREAK_CYCLES + 2;
    localparam int ISO_RST_MAX = ISO_RST_CYCLES + 3;
    localparam int ISO_SW_MAX = ISO_SW_CYCLES + 2;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    logic [31:0] quiet_cnt;
    logic [31:0] next_quiet_cnt;
    logic want_spd;
    logic next_want_spd;
    logic want_dup;
    logic next_want_dup;
    logic ctl_wr;
    // soft reset writes are left out: they restart the isolate count
    assign ctl_wr = reg_write && reg_addr == 5'h00 && !reg_wdata[15];
    always_comb begin
        next_quiet_cnt = tx_silence ? quiet_cnt + 32'h1 : 32'h0;
        next_want_spd = ctl_wr ? reg_wdata[13] : want_spd;
        next_want_dup = ctl_wr ? reg_wdata[8] : want_dup;
    end
    always_ff @(posedge clk) begin
        if (!nrst) begin
            quiet_cnt <= 32'h0;
            want_spd <= 1'b0;
            want_dup <= 1'b0;
        end else begin
            quiet_cnt <= next_quiet_cnt;
            want_spd <= next_want_spd;
            want_dup <= next_want_dup;
        end
    end
    iso_reset_a: assert property ($rose(nrst) |-> ##[1:ISO_RST_MAX] !isolated)
        else $error("isolate held too long after reset");
    iso_clear_a: assert property (ctl_wr && !reg_wdata[10] && isolated
        |-> ##[1:ISO_SW_MAX] !isolated)
        else $error("isolate not left after clear");
    iso_set_a: assert property (ctl_wr && reg_wdata[10] |-> ##[1:2] isolated)
        else $error("isolate not entered");
    forced_mode_a: assert property (ctl_wr && !reg_wdata[12] |-> ##[1:3]
        (speed_100 == want_spd && full_duplex == want_dup))
        else $error("forced speed or duplex not applied");
    break_len_a: assert property (quiet_cnt <= BREAK_MAX)
        else $error("silence lasts too long");
    quiet_line_a: assert property (tx_silence |-> !flp_enable)
        else $error("bursts sent during silence");
    page_sel_a: assert property (flp_enable |-> flp_word[4:0] == 5'h01)
        else $error("base page selector wrong");
    status_bits_a: assert property (reg_addr == 5'h01 |-> reg_rdata[15:11]
        == 5'h0F && reg_rdata[6] && reg_rdata[3])
        else $error("status ability bits wrong");
    summary_mode_a: assert property (reg_addr == 5'h10 && link_up
        |-> reg_rdata[2:0] == {full_duplex, !speed_100, 1'b1})
        else $error("summary disagrees with mode");
    cover property ($rose(link_up));
    cover property ($fell(tx_silence));
    cover property (ctl_wr && reg_wdata[10]);
endmodule // pan_autoneg_checker

/* File: bench/pan_partner.sv */
// link partner model across the cable
`timescale 1ns/1ps
module pan_partner (
    input wire logic clk,
    input wire logic [1:0] mode,
    input wire logic [15:0] ability,
    input wire logic want10,
    input wire logic want100,
    input wire logic flp_enable,
    input wire logic [15:0] flp_word,
    input wire logic tx_silence,
    output logic link_pulse_rx,
    output logic [15:0] page_rx_word,
    output logic page_rx_valid,
    output logic link10_good,
    output logic link100_good
);
    logic [2:0] gap = 3'h0;
    logic sent = 1'b0;
    logic acked = 1'b0;
    logic [15:0] last = 16'h0000;
    logic neg_up;
    // mode 0 quiet, 1 negotiating, 2 forced partner that cannot negotiate
    always @(posedge clk) begin
        gap <= gap + 3'h1;
        page_rx_valid <= mode == 2'd1 && flp_enable && gap == 3'h7;
        if (mode == 2'd1 && flp_enable && gap == 3'h7) begin
            last <= ability | (sent ? 16'h4000 : 16'h0000);
            sent <= 1'b1;
        end
        if (flp_enable && flp_word[14]) begin
            acked <= 1'b1;
        end
        // silence drives a negotiating (mode 1) partner into link fail, as a real one would
        if (mode != 2'd1 || tx_silence) begin
            sent <= 1'b0;
            acked <= 1'b0;
        end
    end
    // undriven page data is scrambled so a stale word cannot pass
    assign page_rx_word = page_rx_valid ? last : ~last;
    assign link_pulse_rx = page_rx_valid;
    assign neg_up = mode == 2'd1 && acked && !tx_silence;
    assign link10_good = want10 && (mode == 2'd2 || neg_up);
    assign link100_good = want100 && (mode == 2'd2 || neg_up);
endmodule // pan_partner

/* File: bench/test_pan_autoneg.sv */
// testbench of the auto-negotiation control block
`timescale 1ns/1ps
module test_pan_autoneg;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [4:0] reg_addr = 5'h00;
    logic reg_write = 1'b0;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata, page_rx_word, flp_word, rv;
    logic link_pulse_rx, page_rx_valid, link10_good, link100_good;
    logic flp_enable, tx_silence, isolated, link_up, speed_100, full_duplex;
    logic [1:0] mode = 2'd0;
    logic [15:0] ability = 16'h01E1;
    logic want10 = 1'b0;
    logic want100 = 1'b0;
    logic strap = 1'b1;
    int err_total = 0;
    int n_compared = 0;
    pan_autoneg #(.BREAK_CYCLES(50), .ISO_RST_CYCLES(20),
        .ISO_SW_CYCLES(10), .NEG_CYCLES(200)) i_dut (.clk(clk), .nrst(nrst),
        .advert_strap_pin(strap), .reg_addr(reg_addr), .reg_write(reg_write),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .link_pulse_rx(link_pulse_rx), .page_rx_word(page_rx_word),
        .page_rx_valid(page_rx_valid), .link10_good(link10_good),
        .link100_good(link100_good), .flp_enable(flp_enable),
        .flp_word(flp_word), .tx_silence(tx_silence), .isolated(isolated),
        .link_up(link_up), .speed_100(speed_100), .full_duplex(full_duplex));
    pan_partner i_partner (.clk(clk), .mode(mode), .ability(ability),
        .want10(want10), .want100(want100), .flp_enable(flp_enable),
        .flp_word(flp_word), .tx_silence(tx_silence),
        .link_pulse_rx(link_pulse_rx), .page_rx_word(page_rx_word),
        .page_rx_valid(page_rx_valid), .link10_good(link10_good),
        .link100_good(link100_good));
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic stop_test();
        if (err_total == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e,
        input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        #1;
        d = reg_rdata;
    endtask
    task automatic wt(ref logic s, input logic v, input int n,
        input string nm);
        int i;
        i = 0;
        #1;
        while (s !== v && i < n) begin
            @(posedge clk);
            #1;
            i++;
        end
        chk(nm, {15'h0, v}, {15'h0, s});
    endtask
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        wt(isolated, 1'b0, 25, "isolated");
        rd(5'h01, rv);
        chk("status_t4", 16'h0, {15'h0, rv[15]});
        rd(5'h04, rv);
        chk("advert", 16'h01E1, rv);
        rd(5'h02, rv);
        chk("unmapped", 16'h0, rv);
        for (int m = 0; m < 4; m++) begin
            wr(5'h00, {2'b00, m[1], 4'h0, m[0], 8'h00});
            wt(speed_100, m[1], 4, "forced_speed");
            wt(full_duplex, m[0], 4, "forced_duplex");
        end
        wr(5'h00, 16'h0400);
        wt(isolated, 1'b1, 3, "iso_on");
        wr(5'h00, 16'h0000);
        wt(isolated, 1'b0, 12, "iso_off");
        wr(5'h04, 16'h0061);
        mode <= 2'd1;
        want10 <= 1'b1;
        wr(5'h00, 16'h1000);
        wt(tx_silence, 1'b1, 3, "silence");
        wt(flp_enable, 1'b1, 60, "flp_on");
        chk("flp_abil", 16'h3, {12'h0, flp_word[8:5]});
        wt(link_up, 1'b1, 300, "link_neg");
        chk("mode_neg", 16'h1, {14'h0, speed_100, full_duplex});
        rd(5'h05, rv);
        chk("partner", 16'h01E1, rv & 16'hBFFF);
        rd(5'h01, rv);
        chk("complete", 16'h3, {14'h0, rv[5], rv[2]});
        rd(5'h10, rv);
        chk("summary", 16'h7, {13'h0, rv[2:0]});
        rd(5'h06, rv);
        chk("exp_able", 16'h1, {15'h0, rv[0]});
        mode <= 2'd0;
        want10 <= 1'b0;
        wt(link_up, 1'b0, 10, "link_lost");
        wt(flp_enable, 1'b1, 80, "renegotiate");
        mode <= 2'd2;
        want100 <= 1'b1;
        wt(link_up, 1'b1, 400, "link_pd");
        chk("mode_pd", 16'h2, {14'h0, speed_100, full_duplex});
        rd(5'h05, rv);
        chk("partner_pd", 16'h0081, rv);
        rd(5'h06, rv);
        chk("exp_pd", 16'h0, {14'h0, rv[4], rv[0]});
        wr(5'h00, 16'h1200);
        strap <= 1'b0;
        wt(tx_silence, 1'b1, 3, "restart");
        want10 <= 1'b1;
        rv = 16'h0000;
        for (int i = 0; i < 400 && rv[4] !== 1'b1; i++) begin
            rd(5'h06, rv);
        end
        chk("pd_fault", 16'h1, {15'h0, rv[4]});
        wr(5'h00, 16'h8000);
        wt(isolated, 1'b1, 3, "iso_soft_on");
        wt(isolated, 1'b0, 25, "iso_soft_off");
        rd(5'h04, rv);
        chk("advert_half", 16'h00A1, rv);
        @(posedge clk);
        nrst <= 1'b0;
        strap <= 1'b1;
        repeat (5) @(posedge clk);
        wt(isolated, 1'b1, 1, "iso_held");
        @(posedge clk);
        nrst <= 1'b1;
        wt(isolated, 1'b0, 25, "iso_rearm");
        rd(5'h04, rv);
        chk("advert_full", 16'h01E1, rv);
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        stop_test();
    end
endmodule // test_pan_autoneg
bind pan_autoneg pan_autoneg_checker #(.BREAK_CYCLES(BREAK_CYCLES),
    .ISO_RST_CYCLES(ISO_RST_CYCLES), .ISO_SW_CYCLES(ISO_SW_CYCLES)) i_chk (
    .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .flp_enable(flp_enable),
    .flp_word(flp_word), .tx_silence(tx_silence), .isolated(isolated),
    .link_up(link_up), .speed_100(speed_100), .full_duplex(full_duplex));
